// File: bench/sfp_core_asserts.sv
// Purpose: port-level checks for sfp_core
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every sfp_core instance
`timescale 1ns/1ns
module sfp_core_chk
	import sfp_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = IDLE_CYC_C
) (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [7:0]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	input wire logic        data_reg_access_in,
	input wire logic        flush_done_in,
	input wire logic        iois16_n_out,
	input wire logic        bit8_mode_out,
	input wire logic        flush_req_out,
	input wire logic        busy_out,
	input wire logic        sleep_out,
	input wire logic        intrq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// command write seen in its ack cycle; low byte lane must be enabled
	logic cmd_w;
	assign cmd_w = wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in[7:2] == ADR_CMD[7:2];
	chk_ack_once: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");
	chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("request not answered next cycle");
	chk_io_narrow: assert property (data_reg_access_in && bit8_mode_out |=> iois16_n_out)
		else $error("wide indication in narrow mode");
	chk_io_wide: assert property (data_reg_access_in && !bit8_mode_out |=> !iois16_n_out)
		else $error("wide indication missing");
	chk_busy_two: assert property ($rose(busy_out) |=> busy_out)
		else $error("busy shorter than two cycles");
	chk_cmd_busy: assert property (cmd_w && !$past(busy_out) |-> busy_out)
		else $error("command did not raise busy");
	chk_cmd_wake: assert property (cmd_w && !$past(busy_out) |-> !sleep_out)
		else $error("command did not wake card");
	chk_done_irq: assert property ($fell(busy_out) |-> intrq_out)
		else $error("completion without interrupt");
	chk_flush_busy: assert property (flush_req_out |-> busy_out)
		else $error("completed before flush");
	chk_flush_hold: assert property (flush_req_out && !flush_done_in |=> flush_req_out)
		else $error("flush request dropped early");
	cover property ($rose(flush_req_out));
	cover property ($rose(sleep_out) && !busy_out);
	cover property (data_reg_access_in && bit8_mode_out);
endmodule // sfp_core_chk

bind sfp_core sfp_core_chk #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.clk_in, .rst_n_in, .wb_cyc_in,
	.wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
	.data_reg_access_in, .flush_done_in, .iois16_n_out, .bit8_mode_out, .flush_req_out,
	.busy_out, .sleep_out, .intrq_out);

// File: bench/sfp_host.sv
// Purpose: host controller writing the task file over wishbone
// Assumes: classic single cycles, slave answers when it likes
// Notes:   never enables narrow mode for dma, it runs no dma at all
`timescale 1ns/1ns
module sfp_host (
	input  wire logic        clk_in,
	input  wire logic        ack_in,
	input  wire logic [31:0] dat_in,
	output logic             cyc_out,
	output logic             stb_out,
	output logic             we_out,
	output logic [7:0]       adr_out,
	output logic [3:0]       sel_out,
	output logic [31:0]      dat_out
);
	initial begin
		{cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
	end
	// released lines show inverted data so stale values never match by luck
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_in);
		{cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} <= {2'b11, w, a, 4'hf, d};
		@(posedge clk_in iff ack_in);
		q = dat_in;
		{cyc_out, stb_out, we_out, adr_out, dat_out} <= {3'b000, ~a, ~d};
	endtask
endmodule // sfp_host

// File: bench/tb.sv
// Purpose: self-checking bench for sfp_core
// Assumes: short idle timer, flush engine answers at random
// Notes:   integer model compared after every command
`timescale 1ns/1ns
module tb;
	import sfp_pkg::*;
	localparam int IDLE_N = 50;
	logic        clk_in = 1'b0, rst_n_in = 1'b0, data_reg_access_in = 1'b0, flush_done_in = 1'b0;
	logic        wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, iois16_n_out, bit8_mode_out;
	logic        flush_req_out, busy_out, sleep_out, intrq_out;
	logic [7:0]  wb_adr_in;
	logic [3:0]  wb_sel_in;
	logic [31:0] wb_dat_in, wb_dat_out, q;
	int mismatches = 0, checked = 0, cfg = 'h84, cap, pio, mdma, mult, men, err, drv = 0, sl, ir;
	int on_c[8] = '{8'h01, 8'h02, 8'haa, 8'h05, 8'h09, 8'h0a, 8'h44, 8'hcc};
	int of_c[8] = '{8'h81, 8'h82, 8'h55, 8'h85, 8'h89, 8'h8a, 8'hbb, 8'h66};
	// last op leaves the card awake so the idle timer test starts from zero
	int ops[6] = '{8'h99, 8'h96, 8'he6, 8'he2, 8'h99, 8'h20};
	always #5 clk_in = ~clk_in;
	sfp_core #(.IDLE_CYCLES(IDLE_N)) uut (.clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
		.wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .data_reg_access_in,
		.flush_done_in, .iois16_n_out, .bit8_mode_out, .flush_req_out, .busy_out, .sleep_out,
		.intrq_out);
	sfp_host host (.clk_in, .ack_in(wb_ack_out), .dat_in(wb_dat_out), .cyc_out(wb_cyc_in),
		.stb_out(wb_stb_in), .we_out(wb_we_in), .adr_out(wb_adr_in), .sel_out(wb_sel_in),
		.dat_out(wb_dat_in));
	// random data-port traffic; flush finishes after a random wait
	always @(posedge clk_in) begin
		data_reg_access_in <= 1'($urandom_range(1));
		flush_done_in <= flush_req_out && $urandom_range(3) == 0;
	end
	task automatic cmp(string nm, int e, logic [31:0] s);
		checked++;
		if (s !== 32'(e)) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, 32'(e), s);
		end
	endtask
	task automatic wr(logic [7:0] a, int d);
		host.xfer(1'b1, a, 32'(d), q);
	endtask
	// status read last: it clears the pending interrupt
	task automatic check_regs(string nm);
		int m;
		m = drv < 0 ? 'h5f : 'h7f;
		host.xfer(1'b0, ADR_MODE, '0, q);
		cmp({nm, " mode"}, pio | mdma << 3 | mult << 8, q);
		host.xfer(1'b0, ADR_CFG, '0, q);
		cmp({nm, " cfg"}, cfg | cap << 8, q);
		host.xfer(1'b0, ADR_CMD, '0, q);
		cmp({nm, " status"}, (err << 1 | ir << 2 | sl << 3 | men << 4 | (drv & 1) << 5) & m, q & m);
		ir = 0;
	endtask
	task automatic cmd(int op, int f, int c, int d);
		int n;
		wr(ADR_FEAT, f);
		wr(ADR_SCNT, c);
		wr(ADR_DRVH, d);
		wr(ADR_CMD, op);
		@(negedge clk_in);
		cmp("busy", 1, busy_out);
		for (n = 0; n < 500 && busy_out !== 1'b0; n++) @(negedge clk_in);
		cmp("busy end", 0, busy_out);
		cmp("irq", 1, intrq_out);
		err = 0;
		ir = 1;
		sl = op == 'h99 || op == 'he6;
		if (op == 'h96 || op == 'he2) drv = d >> 4 & 1;
		if (op == 'hc6) begin
			men = c inside {[1:16]};
			if (men) mult = c;
			err = c > 16;
		end
		if (op == 'hef) begin
			err = !(f inside {'h69, 'h96, 'h97, 'h9a});
			if (f == 'h9a) cap = c;
			if (f == 'h03 && c >> 3 < 2 && c % 8 < 5) pio = c % 8;
			if (f == 'h03 && c >> 3 == 4 && c % 8 < 3) mdma = c % 8;
			if (f == 'h03) err = !(c >> 3 < 2 && c % 8 < 5 || c >> 3 == 4 && c % 8 < 3);
			for (int i = 0; i < 8; i++) begin
				if (f == on_c[i] || f == of_c[i]) begin
					cfg = f == on_c[i] ? cfg | 1 << i : cfg & ~(1 << i);
					err = 0;
				end
			end
		end
		cmp("sleep", sl, sleep_out);
		cmp("narrow", cfg & 1, bit8_mode_out);
		check_regs("cmd");
	endtask
	task automatic soft_rst();
		wr(ADR_CTRL, 1);
		if (cfg >> 7 & 1) {cfg, cap, pio, mdma, mult, men} = {32'h84, 160'h0};
		{err, ir, sl} = 96'h0;
		check_regs("soft");
	endtask
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_in);
		mismatches++;
		summarize();
	end
	initial begin
		void'($urandom(32'h0000_25b3));
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		check_regs("reset");
		wr(8'h1c, 'hff);
		host.xfer(1'b0, 8'h1c, '0, q);
		cmp("unmapped", 0, q);
		for (int f = 0; f < 256; f++) cmd('hef, 0, $urandom_range(255), 0);
		$display("test unknown codes ended");
		for (int f = 0; f < 256; f++) cmd('hef, f, $urandom_range(255), 0);
		$display("test feature codes ended");
		for (int c = 0; c < 256; c++) cmd('hef, 'h03, c, 0);
		$display("test transfer modes ended");
		for (int c = 0; c < 19; c++) cmd('hc6, 0, c == 18 ? 255 : c, 0);
		$display("test block count ended");
		foreach (ops[i]) cmd(ops[i], 0, 0, $urandom_range(255));
		repeat (30) @(negedge clk_in);
		cmp("idle early", 0, sleep_out);
		repeat (25) @(negedge clk_in);
		cmp("idle late", 1, sleep_out);
		sl = 1;
		check_regs("idle");
		$display("test sleep ended");
		cmd('hc6, 0, 8, 0);
		cmd('hef, 'h66, 0, 0);
		soft_rst();
		cmd('hef, 'hcc, 0, 0);
		cmd('hef, 'h01, 0, 0);
		soft_rst();
		$display("test soft reset ended");
		repeat (300) cmd($urandom_range(1) ? 'hef : 'hc6, $urandom_range(255), $urandom_range(255), 0);
		$display("test random ended");
		summarize();
	end
endmodule // tb

// File: shared/sfp_pkg.sv
// Purpose: constants for the set-features / power command decoder
// Assumes: byte-addressed classic wishbone, 32-bit data, 100 MHz clock
// Notes:   register map, opcodes, feature codes, reset values, timing
package sfp_pkg;
	// register byte addresses
	localparam logic [7:0] ADR_FEAT = 8'h00;
	localparam logic [7:0] ADR_SCNT = 8'h04;
	localparam logic [7:0] ADR_DRVH = 8'h08;
	localparam logic [7:0] ADR_CMD  = 8'h0c;
	localparam logic [7:0] ADR_CTRL = 8'h10;
	localparam logic [7:0] ADR_CFG  = 8'h14;
	localparam logic [7:0] ADR_MODE = 8'h18;
	// opcodes
	localparam logic [7:0] OP_SETF   = 8'hef;
	localparam logic [7:0] OP_SETMUL = 8'hc6;
	localparam logic [7:0] OP_SLP_A  = 8'h99;
	localparam logic [7:0] OP_SLP_B  = 8'he6;
	localparam logic [7:0] OP_STB_A  = 8'h96;
	localparam logic [7:0] OP_STB_B  = 8'he2;
	// feature subcommand codes
	localparam logic [7:0] FC_B8_ON  = 8'h01;
	localparam logic [7:0] FC_B8_OFF = 8'h81;
	localparam logic [7:0] FC_WC_ON  = 8'h02;
	localparam logic [7:0] FC_WC_OFF = 8'h82;
	localparam logic [7:0] FC_XFER   = 8'h03;
	localparam logic [7:0] FC_APM_ON = 8'h05;
	localparam logic [7:0] FC_APM_OF = 8'h85;
	localparam logic [7:0] FC_EXP_ON = 8'h09;
	localparam logic [7:0] FC_EXP_OF = 8'h89;
	localparam logic [7:0] FC_PL1_ON = 8'h0a;
	localparam logic [7:0] FC_PL1_OF = 8'h8a;
	localparam logic [7:0] FC_ECC_VS = 8'h44;
	localparam logic [7:0] FC_ECC_4  = 8'hbb;
	localparam logic [7:0] FC_RLA_ON = 8'haa;
	localparam logic [7:0] FC_RLA_OF = 8'h55;
	localparam logic [7:0] FC_POR_OF = 8'h66;
	localparam logic [7:0] FC_POR_ON = 8'hcc;
	localparam logic [7:0] FC_NOP_A  = 8'h69;
	localparam logic [7:0] FC_NOP_B  = 8'h96;
	localparam logic [7:0] FC_NOP_C  = 8'h97;
	localparam logic [7:0] FC_ICAP   = 8'h9a;
	// transfer-mode field of the count value
	localparam logic [4:0] XT_PIO_DEF = 5'h00;
	localparam logic [4:0] XT_PIO     = 5'h01;
	localparam logic [4:0] XT_MDMA    = 5'h04;
	localparam logic [2:0] PIO_MAX    = 3'h4;
	localparam logic [2:0] MDMA_MAX   = 3'h2;
	localparam logic [7:0] MULTI_MAX  = 8'h10;
	localparam logic       WC_PRESENT = 1'b1;
	localparam int         DRV_BIT    = 4;
	// config register bit positions and reset value
	localparam int CF_B8 = 0, CF_WC = 1, CF_RLA = 2, CF_APM = 3;
	localparam int CF_EXP = 4, CF_PL1 = 5, CF_ECCV = 6, CF_POR = 7;
	localparam logic [7:0] CFG_RST = 8'h84;
	// status register bit positions
	localparam int ST_BSY = 0, ST_ERR = 1, ST_IRQ = 2, ST_SLP = 3;
	localparam int ST_MUL = 4, ST_DRV = 5, ST_FLS = 6;
	// idle timer
	localparam int IDLE_MS    = 5;
	localparam int CLK_HZ     = 100_000_000;
	localparam int IDLE_CYC_C = IDLE_MS * (CLK_HZ / 1000);
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_EXEC  = 4'b0010,
		S_FLUSH = 4'b0100,
		S_DONE  = 4'b1000
	} sfp_state_t;
endpackage

// File: verilog/sfp_core.sv
// Purpose: set-features, set-multiple, sleep and standby command decoder
// Assumes: task-file registers written by the host controller over wishbone
// Notes:   one command at a time; command writes while busy are dropped
//
// Summary of operation
// - set features takes subcommand from feature reg, value from sector count
// - 01h enables 8-bit transfers, 81h disables them
// - 8-bit mode uses low lanes only and keeps 16-bit indication off from the cycle after it is set
// - 02h enables write cache, 82h disables it where a cache exists
// - disabling the cache flushes it before the command completes
// - 03h picks transfer type from upper five bits, mode from lower three
// - exactly one pio mode and one multiword dma mode always selected
// - aah enables read look-ahead, 55h disables it
// - 66h keeps settings over soft reset, cch restores defaults on it
// - 05h enables advanced power management, 85h disables it
// - 09h enables extended power operations, 89h disables them
// - 0ah permits power level 1 commands, 8ah forbids them
// - 44h selects vendor ecc bytes on long commands, bbh four bytes
// - 69h, 96h, 97h accepted as no-ops
// - 9ah records the host current source capability
// - set multiple raises busy then checks sector count
// - valid supported count is stored and multiple commands enabled
// - unsupported count aborts and disables; zero count disables
// - multiple mode disabled after power-on, hard reset, default soft reset
// - sleep opcodes raise busy, sleep, then drop busy and interrupt on the same edge
// - any new command wakes the card from sleep
// - idle timer of 5 ms puts the card to sleep by itself
// - both standby opcodes decode alike, drive bit from drive/head
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module sfp_core
	import sfp_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = IDLE_CYC_C
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        data_reg_access_in,
	input  wire logic        flush_done_in,
	output logic             iois16_n_out,
	output logic             bit8_mode_out,
	output logic             flush_req_out,
	output logic             busy_out,
	output logic             sleep_out,
	output logic             intrq_out
);
	sfp_state_t  state_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic [7:0]  feat_q;
	logic [7:0]  scnt_q;
	logic [7:0]  drvh_q;
	logic [7:0]  op_q;
	logic [7:0]  cfg_q;
	logic [7:0]  icap_q;
	logic [2:0]  pio_q;
	logic [2:0]  mdma_q;
	logic [7:0]  multi_q;
	logic        multi_en_q;
	logic        err_q;
	logic        irq_q;
	logic        sleep_q;
	logic        drv_q;
	logic        iois16_n_q;
	logic [19:0] idle_q;
	logic        fire;
	logic        wr_fire;
	logic        cmd_wr;
	logic        soft_rst;
	logic        stat_rd;
	logic        exec;
	logic        abort_d;
	logic        flush_d;
	logic        setf;
	logic        setmul;

	// a request counts once, in the cycle before ack rises
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
		hit = (adr[7:2] == reg_adr[7:2]);
	endfunction

	function automatic logic is_sleep(input logic [7:0] op);
		is_sleep = (op == OP_SLP_A) || (op == OP_SLP_B);
	endfunction

	function automatic logic is_standby(input logic [7:0] op);
		is_standby = (op == OP_STB_A) || (op == OP_STB_B);
	endfunction

	// transfer-mode value check: type and mode must both be supported
	function automatic logic xfer_ok(input logic [7:0] v);
		unique case (v[7:3])
			XT_PIO_DEF, XT_PIO: xfer_ok = (v[2:0] <= PIO_MAX);
			XT_MDMA:            xfer_ok = (v[2:0] <= MDMA_MAX);
			default:            xfer_ok = 1'b0;
		endcase
	endfunction

	// feature code check; 03h also depends on the count value
	function automatic logic feat_ok(input logic [7:0] f, input logic [7:0] v);
		unique case (f)
			FC_B8_ON, FC_B8_OFF, FC_APM_ON, FC_APM_OF,
			FC_EXP_ON, FC_EXP_OF, FC_PL1_ON, FC_PL1_OF,
			FC_ECC_VS, FC_ECC_4, FC_RLA_ON, FC_RLA_OF,
			FC_POR_OF, FC_POR_ON, FC_ICAP: feat_ok = 1'b1;
			FC_NOP_A, FC_NOP_B, FC_NOP_C: feat_ok = 1'b1;
			FC_WC_ON, FC_WC_OFF: feat_ok = WC_PRESENT;
			FC_XFER: feat_ok = xfer_ok(v);
			default: feat_ok = 1'b0;
		endcase
	endfunction

	// bus strobes and command-level events
	assign fire     = wb_cyc_in & wb_stb_in & ~ack_q;
	assign wr_fire  = fire & wb_we_in & wb_sel_in[0];
	assign stat_rd  = fire & ~wb_we_in & hit(wb_adr_in, ADR_CMD);
	assign cmd_wr   = wr_fire & hit(wb_adr_in, ADR_CMD) & (state_q == S_IDLE);
	assign soft_rst = wr_fire & hit(wb_adr_in, ADR_CTRL) & wb_dat_in[0];
	assign exec     = (state_q == S_EXEC);
	assign setf     = exec & (op_q == OP_SETF);
	assign setmul   = exec & (op_q == OP_SETMUL);

	// decision taken in the single execute cycle
	always_comb begin
		abort_d = 1'b0;
		flush_d = 1'b0;
		if (setf) begin
			abort_d = ~feat_ok(feat_q, scnt_q);
			flush_d = (feat_q == FC_WC_OFF) & WC_PRESENT & cfg_q[CF_WC];
		end else if (setmul) begin
			abort_d = (scnt_q > MULTI_MAX);
		end
	end

	// wishbone slave: one-cycle ack, registered read data
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= fire;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dat_q <= 32'h0000_0000;
		end else if (fire && !wb_we_in) begin
			dat_q <= 32'h0000_0000;
			unique case (1'b1)
				hit(wb_adr_in, ADR_FEAT): dat_q[7:0] <= feat_q;
				hit(wb_adr_in, ADR_SCNT): dat_q[7:0] <= scnt_q;
				hit(wb_adr_in, ADR_DRVH): dat_q[7:0] <= drvh_q;
				hit(wb_adr_in, ADR_CMD): begin
					dat_q[ST_BSY] <= busy_out;
					dat_q[ST_ERR] <= err_q;
					dat_q[ST_IRQ] <= irq_q;
					dat_q[ST_SLP] <= sleep_q;
					dat_q[ST_MUL] <= multi_en_q;
					dat_q[ST_DRV] <= drv_q;
					dat_q[ST_FLS] <= flush_req_out;
				end
				hit(wb_adr_in, ADR_CFG): dat_q[15:0] <= {icap_q, cfg_q};
				hit(wb_adr_in, ADR_MODE): dat_q[15:0] <= {multi_q, 2'b00, mdma_q, pio_q};
				default: dat_q <= 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// task-file registers the host loads before a command
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			feat_q <= 8'h00;
			scnt_q <= 8'h00;
			drvh_q <= 8'h00;
			op_q   <= 8'h00;
		end else if (wr_fire && state_q == S_IDLE) begin
			if (hit(wb_adr_in, ADR_FEAT)) begin
				feat_q <= wb_dat_in[7:0];
			end
			if (hit(wb_adr_in, ADR_SCNT)) begin
				scnt_q <= wb_dat_in[7:0];
			end
			if (hit(wb_adr_in, ADR_DRVH)) begin
				drvh_q <= wb_dat_in[7:0];
			end
			if (cmd_wr) begin
				op_q <= wb_dat_in[7:0];
			end
		end
	end

	// command sequencer; soft reset abandons any command in flight
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= S_IDLE;
		end else if (soft_rst) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE:  if (cmd_wr) state_q <= S_EXEC;
				S_EXEC:  state_q <= flush_d ? S_FLUSH : S_DONE;
				S_FLUSH: if (flush_done_in) state_q <= S_DONE;
				S_DONE:  state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// flush request held until the cache reports it is clean
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flush_req_out <= 1'b0;
		end else if (soft_rst) begin
			flush_req_out <= 1'b0;
		end else if (exec && flush_d) begin
			flush_req_out <= 1'b1;
		end else if (state_q == S_FLUSH && flush_done_in) begin
			flush_req_out <= 1'b0;
		end
	end

	// error flag: set on abort, cleared by the next command
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_q <= 1'b0;
		end else if (exec) begin
			err_q <= abort_d;
		end else if (cmd_wr || soft_rst) begin
			err_q <= 1'b0;
		end
	end

	// interrupt pending: completion sets it, status read clears it;
	// set beats a status-read clear; only a soft reset in the same cycle drops a completion
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_q <= 1'b0;
		end else if (state_q == S_DONE && !soft_rst) begin
			irq_q <= 1'b1;
		end else if (stat_rd || cmd_wr || soft_rst) begin
			irq_q <= 1'b0;
		end
	end

	// feature settings; a rejected code leaves every setting alone
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_q  <= CFG_RST;
			icap_q <= 8'h00;
			pio_q  <= 3'h0;
			mdma_q <= 3'h0;
		end else if (soft_rst) begin
			if (cfg_q[CF_POR]) begin
				cfg_q  <= CFG_RST;
				icap_q <= 8'h00;
				pio_q  <= 3'h0;
				mdma_q <= 3'h0;
			end
		end else if (setf && !abort_d) begin
			unique case (feat_q)
				FC_B8_ON:  cfg_q[CF_B8]   <= 1'b1;
				FC_B8_OFF: cfg_q[CF_B8]   <= 1'b0;
				FC_WC_ON:  cfg_q[CF_WC]   <= 1'b1;
				FC_WC_OFF: cfg_q[CF_WC]   <= 1'b0;
				FC_RLA_ON: cfg_q[CF_RLA]  <= 1'b1;
				FC_RLA_OF: cfg_q[CF_RLA]  <= 1'b0;
				FC_APM_ON: cfg_q[CF_APM]  <= 1'b1;
				FC_APM_OF: cfg_q[CF_APM]  <= 1'b0;
				FC_EXP_ON: cfg_q[CF_EXP]  <= 1'b1;
				FC_EXP_OF: cfg_q[CF_EXP]  <= 1'b0;
				FC_PL1_ON: cfg_q[CF_PL1]  <= 1'b1;
				FC_PL1_OF: cfg_q[CF_PL1]  <= 1'b0;
				FC_ECC_VS: cfg_q[CF_ECCV] <= 1'b1;
				FC_ECC_4:  cfg_q[CF_ECCV] <= 1'b0;
				FC_POR_OF: cfg_q[CF_POR]  <= 1'b0;
				FC_POR_ON: cfg_q[CF_POR]  <= 1'b1;
				FC_ICAP:   icap_q <= scnt_q;
				// mode held as a number, so exactly one is always selected
				FC_XFER: begin
					if (scnt_q[7:3] == XT_MDMA) begin
						mdma_q <= scnt_q[2:0];
					end else begin
						pio_q <= scnt_q[2:0];
					end
				end
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// multiple-sector block count and enable
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			multi_q    <= 8'h00;
			multi_en_q <= 1'b0;
		end else if (soft_rst) begin
			if (cfg_q[CF_POR]) begin
				multi_q    <= 8'h00;
				multi_en_q <= 1'b0;
			end
		end else if (setmul) begin
			if (abort_d || scnt_q == 8'h00) begin
				multi_en_q <= 1'b0;
			end else begin
				multi_q    <= scnt_q;
				multi_en_q <= 1'b1;
			end
		end
	end

	// standby drive select latched from drive/head
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drv_q <= 1'b0;
		end else if (exec && is_standby(op_q)) begin
			drv_q <= drvh_q[DRV_BIT];
		end
	end

	// idle timer runs only while quiet and awake
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			idle_q <= 20'h0_0000;
		end else if (cmd_wr || soft_rst || state_q != S_IDLE || sleep_q) begin
			idle_q <= 20'h0_0000;
		end else begin
			idle_q <= idle_q + 20'h0_0001;
		end
	end

	// sleep: command wake beats timer expiry
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sleep_q <= 1'b0;
		end else if (cmd_wr || soft_rst) begin
			sleep_q <= 1'b0;
		end else if (exec && is_sleep(op_q)) begin
			sleep_q <= 1'b1;
		end else if (idle_q == 20'(IDLE_CYCLES - 1)) begin
			sleep_q <= 1'b1;
		end
	end

	// 16-bit indication, registered; not asserted from the cycle after 8-bit mode is set
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			iois16_n_q <= 1'b1;
		end else begin
			iois16_n_q <= ~(data_reg_access_in & ~cfg_q[CF_B8]);
		end
	end

	// outputs
	assign wb_ack_out    = ack_q;
	assign wb_dat_out    = dat_q;
	assign iois16_n_out  = iois16_n_q;
	assign bit8_mode_out = cfg_q[CF_B8];
	assign busy_out      = (state_q != S_IDLE);
	assign sleep_out     = sleep_q;
	assign intrq_out     = irq_q;
endmodule // sfp_core
